// >>> logic/fcg_fast_conv_gpio.sv
// Purpose: Control registers for fast conversion, pins and current sources.
// Assumes: Register port driven by the serial interface on mclk.
// Notes: The converter strobe is asynchronous and is sampled here.
//
// Summary of operation
// [RL1] Fast control bit 0 turns continuous fast conversion on or off.
// [RL2] Fast results enter the result buffer only if a channel is selected.
// [RL3] Bits 1 to 3 select channels; start follows enable rise or command.
// [RL4] Pin drive codes: 00 tristate, 01 low, 10 toggle 400kHz, 11 high.
// [RL5] Pin 5 field at 0xF1 bits 1:0; pins 1 to 4 in 0xF2 pairs.
// [RL6] Heartbeat pins 4 and 5 toggle, then go static low on alert.
// [RL7] Pin 5 heartbeat follows overcurrent enables and alerts, overriding field.
// [RL8] Heartbeat control bit 0 makes pin 4 a heartbeat stopped by alerts.
// [RL9] Enabled pin 4 heartbeat overrides the pin 4 drive field.
// [RL10] Bits 4 and 6 of 0xF1 pick sink or source direction.
// [RL11] Bits 5 and 7 of 0xF1 switch the current sources on.
// [RL12] A source connects only while its input is attached and converting.
// [RL13] Host writes 0xF1 to 0xF4, starts, reads, then rewrites.
// [RL14] Writes to 0xF1 wait and take effect at the next 0xF2 write.
// [RL15] Host writes 0xF1 and 0xF2 together in one burst; the bench writes 0xF1 apart from 0xF2 in t_pins and t_sources.
// [RL16] Host keeps 0xF2 and 0xF5 writes at least 1ms apart.
// [RL17] Register 0xFC holds the eight-bit indirect read pointer.
// [RL18] Debug counter counts milliseconds, cleared once per core cycle.
// [RL19] Debug counter wraps after 100 in measure, 17 in standby.
// [RL20] Host leaves the auxiliary selection alone during continuous mode; the bench sets bit 1 of 0xF5 while it is on.
// [RL21] A heartbeat stopped by alert stays low until the alert clears.
`timescale 1ns/1ps

module fcg_fast_conv_gpio import fcg_pkg::*; #(
  parameter int DATA_W = 16,
  parameter int START_CYC = FCG_FAST_START_CYC
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic resetn,
  // Register port from the serial interface.
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Commands and core events.
  input wire logic conversion_start_command,
  input wire logic ms_tick,
  input wire logic core_cycle_done,
  input wire logic measure_mode,
  // Alert sources.
  input wire logic [1:0] oc_comp_enable,
  input wire logic oc_alert,
  input wire logic unmasked_alert,
  // Converter state.
  input wire logic pos_attached,
  input wire logic neg_attached,
  output logic fast_start,
  output logic fast_continuous,
  output logic [2:0] fast_channels,
  // Converter result strobe and data, asynchronous.
  input wire logic adc_strobe,
  input wire logic [DATA_W-1:0] adc_data,
  // Result stream towards the result memory.
  output logic res_valid,
  input wire logic res_ready,
  output logic [DATA_W-1:0] res_data,
  output logic res_overrun,
  // Current sources.
  output logic pos_source_connect,
  output logic pos_source_direction,
  output logic neg_source_connect,
  output logic neg_source_direction,
  // Indirect read pointer.
  output logic [7:0] indirect_read_pointer,
  // General-purpose pins.
  input wire logic [4:0] gpio_in,
  output logic [4:0] gpio_out,
  output logic [4:0] gpio_oe
);

  initial begin
    if (DATA_W < 1 || START_CYC < 1 || START_CYC > 4096) begin
      $error("fcg_fast_conv_gpio parameters out of range");
    end
  end

  function automatic logic [1:0] drive_pin(input logic [1:0] code,
                                           input logic wave);
    // Returns {oe, out}.
    case (fcg_drive_t'(code))
      FCG_DRV_LOW: drive_pin = 2'h2;
      FCG_DRV_TOGGLE: drive_pin = {1'b1, wave};
      FCG_DRV_HIGH: drive_pin = 2'h3;
      default: drive_pin = 2'h0;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [7:0] fast_conv_control_reg, heartbeat4_control_reg;
  logic [7:0] cursrc_pin5_control_reg, cursrc_active_reg;
  logic [7:0] pin_drive_control_reg, pointer_reg;
  logic [7:0] debug_ms_counter_reg, dbg_next, dbg_wrap;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      fast_conv_control_reg <= FCG_RST_REG;
      heartbeat4_control_reg <= FCG_RST_REG;
      cursrc_pin5_control_reg <= FCG_RST_REG;
      pin_drive_control_reg <= FCG_RST_REG;
      pointer_reg <= FCG_RST_REG;
    end else if (reg_wr) begin
      if (reg_addr == FCG_OFS_FAST_CTRL) begin
        fast_conv_control_reg <= {4'h0, reg_wdata[3:0]}; // [RL1] [RL3]
      end else if (reg_addr == FCG_OFS_HB4_CTRL) begin
        heartbeat4_control_reg <= {7'h00, reg_wdata[FCG_BIT_HB4_EN]}; // [RL8]
      end else if (reg_addr == FCG_OFS_CURSRC_PIN5) begin
        cursrc_pin5_control_reg <= {reg_wdata[7:4], 2'h0, reg_wdata[1:0]};
      end else if (reg_addr == FCG_OFS_PIN_DRIVE) begin
        pin_drive_control_reg <= reg_wdata; // [RL5]
      end else if (reg_addr == FCG_OFS_RD_POINTER) begin
        pointer_reg <= reg_wdata; // [RL17]
      end
    end
  end

  // The written 0xF1 value stays pending so pin and source settings
  // of one burst change together at the 0xF2 write.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cursrc_active_reg <= FCG_RST_REG;
    end else if (reg_wr && reg_addr == FCG_OFS_PIN_DRIVE) begin
      cursrc_active_reg <= cursrc_pin5_control_reg; // [RL14] [RL15]
    end
  end

  assign indirect_read_pointer = pointer_reg; // [RL17]

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      reg_rdata <= FCG_RDATA_UNMAPPED;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (!reg_rd) begin
        reg_rdata <= reg_rdata;
      end else if (reg_addr == FCG_OFS_FAST_CTRL) begin
        reg_rdata <= fast_conv_control_reg;
      end else if (reg_addr == FCG_OFS_HB4_CTRL) begin
        reg_rdata <= heartbeat4_control_reg;
      end else if (reg_addr == FCG_OFS_CURSRC_PIN5) begin
        reg_rdata <= cursrc_pin5_control_reg;
      end else if (reg_addr == FCG_OFS_PIN_DRIVE) begin
        reg_rdata <= pin_drive_control_reg;
      end else if (reg_addr == FCG_OFS_RD_POINTER) begin
        reg_rdata <= pointer_reg;
      end else if (reg_addr == FCG_OFS_DEBUG_CNT) begin
        reg_rdata <= debug_ms_counter_reg;
      end else begin
        reg_rdata <= FCG_RDATA_UNMAPPED;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Debug millisecond counter.

  assign dbg_wrap = measure_mode ? FCG_DBG_WRAP_MEASURE
                                 : FCG_DBG_WRAP_STANDBY;
  assign dbg_next = (debug_ms_counter_reg >= dbg_wrap) ? 8'h00
                                            : debug_ms_counter_reg + 8'h01;

  // The core-cycle clear wins over a tick in the same cycle.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      debug_ms_counter_reg <= 8'h00;
    end else if (core_cycle_done) begin
      debug_ms_counter_reg <= 8'h00; // [RL18]
    end else if (ms_tick) begin
      debug_ms_counter_reg <= dbg_next; // [RL18] [RL19]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Fast conversion start.

  fcg_start_t state_reg;
  logic [12:0] start_cnt_reg, ast_age_reg;
  logic cont_d_reg, start_req;

  assign fast_continuous = fast_conv_control_reg[FCG_BIT_FAST_CONT]; // [RL1]
  assign fast_channels = fast_conv_control_reg[FCG_BIT_FAST_CH2:
                                               FCG_BIT_FAST_AUX]; // [RL3]
  assign start_req = (fast_continuous && !cont_d_reg) ||
                     conversion_start_command; // [RL3]

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cont_d_reg <= 1'b0;
    end else begin
      cont_d_reg <= fast_continuous;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_reg <= FCG_ST_IDLE;
      start_cnt_reg <= 13'h0000;
    end else begin
      case (state_reg)
        FCG_ST_IDLE: begin
          if (start_req) begin
            state_reg <= FCG_ST_WAIT;
            start_cnt_reg <= 13'h0000;
          end
        end
        FCG_ST_WAIT: begin
          if (start_cnt_reg == 13'(START_CYC - 1)) begin
            state_reg <= FCG_ST_FIRE; // [RL3]
          end else begin
            start_cnt_reg <= start_cnt_reg + 13'h0001;
          end
        end
        default: begin
          state_reg <= FCG_ST_IDLE;
        end
      endcase
    end
  end

  assign fast_start = (state_reg == FCG_ST_FIRE);

  //////////////////////////////////////////////////////////////////////////
  // Result capture from the asynchronous converter strobe.

  logic [2:0] strobe_sync_reg;
  logic [DATA_W-1:0] data_meta_reg, data_sync_reg;
  logic strobe_rise, push_ok, buf_ready;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      strobe_sync_reg <= 3'h0;
    end else begin
      strobe_sync_reg <= {strobe_sync_reg[1:0], adc_strobe};
    end
  end

  always_ff @(posedge mclk) begin
    data_meta_reg <= adc_data;
    data_sync_reg <= data_meta_reg;
  end

  // Only the second and third stages are looked at for the edge.
  assign strobe_rise = strobe_sync_reg[1] && !strobe_sync_reg[2];
  assign push_ok = strobe_rise && (fast_channels != 3'h0); // [RL2]

  // A strobe that finds the buffer full is dropped and flagged; the flag holds only while continuous mode is on.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      res_overrun <= 1'b0;
    end else if (push_ok && !buf_ready) begin
      res_overrun <= 1'b1;
    end else if (!fast_continuous) begin
      res_overrun <= 1'b0;
    end
  end

  fcg_pair_buffer #(.WIDTH(DATA_W)) u_buffer (
    .mclk(mclk),
    .resetn(resetn),
    .in_valid(push_ok),
    .in_ready(buf_ready),
    .in_data(data_sync_reg),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data)
  );

  //////////////////////////////////////////////////////////////////////////
  // Current sources.

  assign pos_source_direction = cursrc_active_reg[FCG_BIT_POS_DIR]; // [RL10]
  assign neg_source_direction = cursrc_active_reg[FCG_BIT_NEG_DIR]; // [RL10]
  assign pos_source_connect = cursrc_active_reg[FCG_BIT_POS_ON] &&
                              pos_attached; // [RL11] [RL12]
  assign neg_source_connect = cursrc_active_reg[FCG_BIT_NEG_ON] &&
                              neg_attached; // [RL11] [RL12]

  //////////////////////////////////////////////////////////////////////////
  // Pins and heartbeats.

  logic wave, hb4_stop_reg, hb5_stop_reg, hb4_on, hb5_on;
  logic [1:0] drv [0:4];

  fcg_toggle_gen #(.HALF_CYC(FCG_TOGGLE_HALF_CYC)) u_toggle (
    .mclk(mclk),
    .resetn(resetn),
    .wave(wave)
  );

  assign hb4_on = heartbeat4_control_reg[FCG_BIT_HB4_EN]; // [RL8]
  assign hb5_on = (oc_comp_enable != 2'h0); // [RL7]

  // Alerts are sticky upstream, so the stop follows the alert level.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      hb4_stop_reg <= 1'b0;
      hb5_stop_reg <= 1'b0;
    end else begin
      hb4_stop_reg <= hb4_on && unmasked_alert; // [RL8] [RL21]
      hb5_stop_reg <= hb5_on && oc_alert; // [RL7] [RL21]
    end
  end

  always_comb begin
    drv[0] = drive_pin(pin_drive_control_reg[1:0], wave); // [RL4] [RL5]
    drv[1] = drive_pin(pin_drive_control_reg[3:2], wave);
    drv[2] = drive_pin(pin_drive_control_reg[5:4], wave);
    if (hb4_on) begin
      drv[3] = {1'b1, wave && !hb4_stop_reg}; // [RL6] [RL9]
    end else begin
      drv[3] = drive_pin(pin_drive_control_reg[7:6], wave);
    end
    if (hb5_on) begin
      drv[4] = {1'b1, wave && !hb5_stop_reg}; // [RL6] [RL7]
    end else begin
      drv[4] = drive_pin(cursrc_active_reg[1:0], wave); // [RL5] [RL14]
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      gpio_out <= 5'h00;
      gpio_oe <= 5'h00;
    end else begin
      for (int i = 0; i < 5; i++) begin
        gpio_oe[i] <= drv[i][1];
        gpio_out[i] <= drv[i][0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // Own count of wait cycles, so a start that hangs is caught.
  always_ff @(posedge mclk) begin
    if (!resetn || fast_start) begin
      ast_age_reg <= 13'h0000;
    end else if (state_reg == FCG_ST_WAIT) begin
      ast_age_reg <= ast_age_reg + 13'h0001;
    end
  end

  AST_F1_PENDING: assert property ( // [RL14]
    reg_wr && reg_addr == FCG_OFS_CURSRC_PIN5 ##1 !reg_wr [*2]
    |-> $stable(pos_source_direction) && $stable(neg_source_direction))
    else $error("0xF1 write took effect without 0xF2 write");
  AST_F2_COMMIT: assert property ( // [RL14]
    reg_wr && reg_addr == FCG_OFS_PIN_DRIVE |=>
    cursrc_active_reg == $past(cursrc_pin5_control_reg))
    else $error("0xF2 write did not commit pending settings");
  AST_NO_PUSH_UNSELECTED: assert property ( // [RL2]
    fast_channels == 3'h0 |-> !push_ok)
    else $error("result pushed with no channel selected");
  AST_START_DELAY: assert property ( // [RL3]
    fast_start ? ast_age_reg == 13'(START_CYC)
               : ast_age_reg <= 13'(START_CYC))
    else $error("fast start not issued after delay");
  AST_SRC_CONNECT: assert property ( // [RL12]
    pos_source_connect |-> pos_attached && cursrc_active_reg[FCG_BIT_POS_ON])
    else $error("source connected while input not converting");
  AST_HB4_LOW: assert property ( // [RL6]
    hb4_on && unmasked_alert [*3] |-> gpio_oe[3] && !gpio_out[3])
    else $error("pin 4 heartbeat not low on alert");
  AST_HB5_OVERRIDE: assert property ( // [RL7]
    hb5_on && oc_alert [*3] |-> gpio_oe[4] && !gpio_out[4])
    else $error("pin 5 heartbeat not low on overcurrent alert");
  AST_HB4_OVERRIDE: assert property ( // [RL9]
    $past(hb4_on) && $past(hb4_on, 2) |-> gpio_oe[3])
    else $error("pin 4 heartbeat did not override drive field");
  AST_DRIVE_HIGH: assert property ( // [RL4]
    pin_drive_control_reg[1:0] == 2'h3 [*2] |-> gpio_oe[0] && gpio_out[0])
    else $error("pin 1 not driven high");
  AST_DBG_CLEAR: assert property ( // [RL18]
    core_cycle_done |=> debug_ms_counter_reg == 8'h00)
    else $error("debug counter not cleared");
  AST_DBG_WRAP: assert property ( // [RL19]
    debug_ms_counter_reg <= FCG_DBG_WRAP_MEASURE)
    else $error("debug counter beyond measure wrap");
  AST_POINTER: assert property ( // [RL17]
    reg_wr && reg_addr == FCG_OFS_RD_POINTER |=>
    indirect_read_pointer == $past(reg_wdata))
    else $error("indirect pointer not written");

  COV_FAST_START: cover property (start_req ##[1:200] fast_start);
  COV_RESULT: cover property (res_valid && res_ready);
  COV_COMMIT: cover property (reg_wr && reg_addr == FCG_OFS_PIN_DRIVE);
  COV_HB4_STOP: cover property (hb4_on && hb4_stop_reg);

endmodule // fcg_fast_conv_gpio

// >>> logic/fcg_pair_buffer.sv
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Push and pop may happen in the same cycle.
// Notes: Full is honest, so a stalled drain refuses the next word.
`timescale 1ns/1ps

module fcg_pair_buffer #(
  parameter int WIDTH = 16
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic resetn,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  initial begin
    if (WIDTH < 1) begin
      $error("WIDTH must be positive");
    end
  end

  logic [WIDTH-1:0] mem_reg [0:1];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg ^ push;
      rd_ptr_reg <= rd_ptr_reg ^ pop;
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule // fcg_pair_buffer

// >>> logic/fcg_pkg.sv
// Purpose: Shared constants and types of the fast conversion and pin block.
// Assumes: Core clock mclk at 50 MHz.
// Notes: Register offsets are the byte addresses of the serial register map.

package fcg_pkg;

  // Register offsets.
  localparam logic [7:0] FCG_OFS_DEBUG_CNT = 8'hD5;
  localparam logic [7:0] FCG_OFS_HB4_CTRL = 8'hE8;
  localparam logic [7:0] FCG_OFS_CURSRC_PIN5 = 8'hF1;
  localparam logic [7:0] FCG_OFS_PIN_DRIVE = 8'hF2;
  localparam logic [7:0] FCG_OFS_FAST_CTRL = 8'hF5;
  localparam logic [7:0] FCG_OFS_RD_POINTER = 8'hFC;

  // Reset values.
  localparam logic [7:0] FCG_RST_REG = 8'h00;
  localparam logic [7:0] FCG_RDATA_UNMAPPED = 8'h00;

  // Field positions.
  localparam int FCG_BIT_FAST_CONT = 0;
  localparam int FCG_BIT_FAST_AUX = 1;
  localparam int FCG_BIT_FAST_CH1 = 2;
  localparam int FCG_BIT_FAST_CH2 = 3;
  localparam int FCG_BIT_HB4_EN = 0;
  localparam int FCG_BIT_POS_DIR = 4;
  localparam int FCG_BIT_POS_ON = 5;
  localparam int FCG_BIT_NEG_DIR = 6;
  localparam int FCG_BIT_NEG_ON = 7;

  // Debug counter wrap points.
  localparam logic [7:0] FCG_DBG_WRAP_MEASURE = 8'h64;
  localparam logic [7:0] FCG_DBG_WRAP_STANDBY = 8'h11;

  // Times and cycle counts.
  localparam int FCG_CLK_PERIOD_NS = 20;
  localparam int FCG_TOGGLE_HALF_NS = 1250;
  localparam int FCG_TOGGLE_HALF_CYC = FCG_TOGGLE_HALF_NS / FCG_CLK_PERIOD_NS;
  localparam int FCG_FAST_START_NS = 2000;
  localparam int FCG_FAST_START_CYC =
    (FCG_FAST_START_NS + FCG_CLK_PERIOD_NS - 1) / FCG_CLK_PERIOD_NS;

  // Two-bit pin drive codes.
  typedef enum logic [1:0] {
    FCG_DRV_TRISTATE = 2'h0,
    FCG_DRV_LOW = 2'h1,
    FCG_DRV_TOGGLE = 2'h2,
    FCG_DRV_HIGH = 2'h3
  } fcg_drive_t;

  // Fast start sequencer, Gray coded from IDLE to FIRE; the return to IDLE flips both bits.
  typedef enum logic [1:0] {
    FCG_ST_IDLE = 2'h0,
    FCG_ST_WAIT = 2'h1,
    FCG_ST_FIRE = 2'h3
  } fcg_start_t;

endpackage

// >>> logic/fcg_toggle_gen.sv
// Purpose: Free running square wave for the toggling pin mode.
// Assumes: HALF_CYC core cycles per half period.
// Notes: Shared by all five pins so they toggle in phase.
`timescale 1ns/1ps

module fcg_toggle_gen import fcg_pkg::*; #(
  parameter int HALF_CYC = FCG_TOGGLE_HALF_CYC
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic resetn,
  // Square wave.
  output logic wave
);

  initial begin
    if (HALF_CYC < 1 || HALF_CYC > 255) begin
      $error("HALF_CYC out of range");
    end
  end

  logic [7:0] cnt_reg;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cnt_reg <= 8'h00;
    end else if (cnt_reg == 8'(HALF_CYC - 1)) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wave <= 1'b0;
    end else if (cnt_reg == 8'(HALF_CYC - 1)) begin
      wave <= ~wave;
    end
  end

endmodule // fcg_toggle_gen

// >>> test/fcg_host.sv
// Purpose: Host model that drives the register port of the block.
// Assumes: One byte per mclk edge; strobes change just after an edge.
// Notes: Callers other than block lower the strobes with idle before a gap wait.
`timescale 1ns/1ps

module fcg_host import fcg_pkg::*; (
  // Clock.
  input wire logic mclk,
  // Register port.
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  realtime t_f2 = -1.0e7;
  realtime t_f5 = -1.0e7;

  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    while ((a == FCG_OFS_PIN_DRIVE && $realtime < t_f5 + 1.0e6) ||
           (a == FCG_OFS_FAST_CTRL && $realtime < t_f2 + 1.0e6))
      @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    if (a == FCG_OFS_PIN_DRIVE) t_f2 = $realtime;
    if (a == FCG_OFS_FAST_CTRL) t_f5 = $realtime;
  endtask

  task automatic idle();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
  endtask

  // Mux bytes are only rewritten while continuous mode is off.
  task automatic block(input logic [7:0] f1, input logic [7:0] f2);
    wr(FCG_OFS_CURSRC_PIN5, f1);
    wr(FCG_OFS_PIN_DRIVE, f2);
    wr(8'hF3, 8'h00);
    wr(8'hF4, 8'h00);
    idle();
  endtask
endmodule // fcg_host

// >>> test/testbench.sv
// Purpose: Self-checking bench for the fast conversion and pin block.
// Assumes: Host model drives the register port; bench drives the rest.
// Notes: START_CYC is cut to 3 so start pulses come quickly.
`timescale 1ns/1ps

module testbench import fcg_pkg::*;;
  logic mclk = 1'b0, resetn = 1'b0, reg_wr, reg_rd, reg_rvalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, indirect_read_pointer, d;
  logic conversion_start_command = 1'b0, ms_tick = 1'b0;
  logic core_cycle_done = 1'b0, measure_mode = 1'b0, oc_alert = 1'b0;
  logic unmasked_alert = 1'b0, pos_attached = 1'b0, neg_attached = 1'b0;
  logic adc_strobe = 1'b0, res_ready = 1'b0;
  logic [1:0] oc_comp_enable = 2'h0;
  logic [15:0] adc_data = 16'h0000, res_data;
  logic [4:0] gpio_in = 5'h00, gpio_out, gpio_oe;
  logic fast_start, fast_continuous, res_valid, res_overrun;
  logic pos_source_connect, pos_source_direction;
  logic neg_source_connect, neg_source_direction;
  logic [2:0] fast_channels;
  int n_errors = 0, checks = 0;

  fcg_fast_conv_gpio #(.DATA_W(16), .START_CYC(3)) fcg_fast_conv_gpio_i (
    .mclk, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .conversion_start_command, .ms_tick, .core_cycle_done,
    .measure_mode, .oc_comp_enable, .oc_alert, .unmasked_alert,
    .pos_attached, .neg_attached, .fast_start, .fast_continuous,
    .fast_channels, .adc_strobe, .adc_data, .res_valid, .res_ready,
    .res_data, .res_overrun, .pos_source_connect, .pos_source_direction,
    .neg_source_connect, .neg_source_direction, .indirect_read_pointer,
    .gpio_in, .gpio_out, .gpio_oe);
  fcg_host fcg_host_i (.mclk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rvalid);

  initial begin
    forever #10 mclk = ~mclk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      n_errors++;
      $display("BAD t=%0t wait limit used up", $time);
      finish_test();
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    fcg_host_i.wr(a, v);
    fcg_host_i.idle();
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    fcg_host_i.rd(a, d);
    chk(16'(d), 16'(e));
  endtask

  task automatic pin(input int p, input logic oe, input logic o);
    chk(16'(gpio_oe[p]), 16'(oe));
    if (oe) chk(16'(gpio_out[p]), 16'(o));
  endtask

  // A toggling pin must show two edges exactly a half period apart.
  task automatic toggles(input int p);
    int n;
    logic v;
    chk(16'(gpio_oe[p]), 16'h0001);
    for (int k = 0; k < 3; k++) begin
      v = gpio_out[p];
      for (n = 0; n < 200 && gpio_out[p] === v; n++) @(posedge mclk);
      bound(n, 200);
    end
    chk(16'(n), 16'(FCG_TOGGLE_HALF_CYC));
  endtask

  task automatic start_wait();
    int n;
    for (n = 0; n < 20 && fast_start !== 1'b1; n++) @(posedge mclk);
    bound(n, 20);
    chk(16'(n), 16'h0004);
    @(posedge mclk);
    chk(16'(fast_start), 16'h0000);
  endtask

  task automatic strobe(input logic [15:0] v);
    adc_data <= v;
    @(posedge mclk);
    adc_strobe <= 1'b1;
    cyc(3);
    adc_strobe <= 1'b0;
    cyc(6);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      ms_tick <= 1'b1;
      @(posedge mclk);
      ms_tick <= 1'b0;
      @(posedge mclk);
    end
  endtask

  task automatic clr();
    core_cycle_done <= 1'b1;
    @(posedge mclk);
    core_cycle_done <= 1'b0;
    @(posedge mclk);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_fast();
    rdc(FCG_OFS_FAST_CTRL, 8'h00);
    rdc(8'h10, 8'h00);
    wr(FCG_OFS_FAST_CTRL, 8'h01);
    start_wait();
    chk(16'(fast_continuous), 16'h0001);
    strobe(16'h1111);
    chk(16'(res_valid), 16'h0000);
    wr(FCG_OFS_FAST_CTRL, 8'h03);
    chk(16'(fast_channels), 16'h0001);
    strobe(16'hA5A1);
    strobe(16'h5A52);
    strobe(16'h3C33);
    chk(16'(res_overrun), 16'h0001);
    for (int i = 0; i < 2; i++) begin
      chk(16'(res_valid), 16'h0001);
      chk(res_data, i ? 16'h5A52 : 16'hA5A1);
      res_ready <= 1'b1;
      @(posedge mclk);
      res_ready <= 1'b0;
      @(posedge mclk);
    end
    chk(16'(res_valid), 16'h0000);
    wr(FCG_OFS_FAST_CTRL, 8'hFF);
    rdc(FCG_OFS_FAST_CTRL, 8'h0F);
    chk(16'(fast_channels), 16'h0007);
    wr(FCG_OFS_FAST_CTRL, 8'h00);
    chk(16'(fast_continuous), 16'h0000);
    conversion_start_command <= 1'b1;
    @(posedge mclk);
    conversion_start_command <= 1'b0;
    chk(16'(res_overrun), 16'h0000);
    start_wait();
    $display("test fast done");
  endtask

  task automatic t_pins();
    wr(FCG_OFS_CURSRC_PIN5, 8'h0F);
    rdc(FCG_OFS_CURSRC_PIN5, 8'h03);
    chk(16'(gpio_oe), 16'h0000);
    for (int c = 0; c < 4; c++) begin
      fcg_host_i.block(8'(c), 8'hE4);
      cyc(3);
      if (c == 2) toggles(4);
      else pin(4, c != 0, c == 3);
    end
    pin(0, 1'b0, 1'b0);
    pin(1, 1'b1, 1'b0);
    toggles(2);
    pin(3, 1'b1, 1'b1);
    $display("test pins done");
  endtask

  task automatic t_heartbeat();
    wr(FCG_OFS_HB4_CTRL, 8'hFF);
    rdc(FCG_OFS_HB4_CTRL, 8'h01);
    toggles(3);
    unmasked_alert <= 1'b1;
    cyc(4);
    pin(3, 1'b1, 1'b0);
    cyc(100);
    pin(3, 1'b1, 1'b0);
    unmasked_alert <= 1'b0;
    toggles(3);
    wr(FCG_OFS_HB4_CTRL, 8'h00);
    cyc(3);
    pin(3, 1'b1, 1'b1);
    oc_comp_enable <= 2'h2;
    toggles(4);
    unmasked_alert <= 1'b1;
    toggles(4);
    oc_alert <= 1'b1;
    cyc(4);
    pin(4, 1'b1, 1'b0);
    oc_alert <= 1'b0;
    unmasked_alert <= 1'b0;
    oc_comp_enable <= 2'h0;
    cyc(3);
    pin(4, 1'b1, 1'b1);
    $display("test heartbeat done");
  endtask

  task automatic t_sources();
    wr(FCG_OFS_CURSRC_PIN5, 8'hB3);
    pos_attached <= 1'b1;
    cyc(2);
    chk(16'(pos_source_connect), 16'h0000);
    wr(FCG_OFS_PIN_DRIVE, 8'hE4);
    cyc(2);
    chk(16'(pos_source_connect), 16'h0001);
    chk(16'(pos_source_direction), 16'h0001);
    chk(16'(neg_source_connect), 16'h0000);
    neg_attached <= 1'b1;
    pos_attached <= 1'b0;
    cyc(2);
    chk(16'(neg_source_connect), 16'h0001);
    chk(16'(neg_source_direction), 16'h0000);
    chk(16'(pos_source_connect), 16'h0000);
    fcg_host_i.block(8'h43, 8'hE4);
    cyc(2);
    chk(16'(neg_source_connect), 16'h0000);
    chk(16'(neg_source_direction), 16'h0001);
    $display("test sources done");
  endtask

  task automatic t_misc();
    wr(FCG_OFS_RD_POINTER, 8'hA5);
    rdc(FCG_OFS_RD_POINTER, 8'hA5);
    chk(16'(indirect_read_pointer), 16'h00A5);
    for (int m = 0; m < 2; m++) begin
      measure_mode <= m[0];
      clr();
      ticks(m ? 100 : 17);
      rdc(FCG_OFS_DEBUG_CNT, m ? 8'h64 : 8'h11);
      ticks(1);
      rdc(FCG_OFS_DEBUG_CNT, 8'h00);
    end
    ticks(3);
    wr(FCG_OFS_DEBUG_CNT, 8'h55);
    rdc(FCG_OFS_DEBUG_CNT, 8'h03);
    clr();
    rdc(FCG_OFS_DEBUG_CNT, 8'h00);
    $display("test pointer and counter done");
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    chk(16'(gpio_oe), 16'h0000);
    t_fast();
    t_pins();
    t_heartbeat();
    t_sources();
    t_misc();
    finish_test();
  end
endmodule // testbench
